// ==== include/tmf_consts.vh ====
// constants of the scheduled window framer: register map, fields, timing
// assumes a 25 MHz system clock and one-microsecond schedule ticks
`ifndef TMF_CONSTS_VH
`define TMF_CONSTS_VH
// timing
`define TMF_CLK_NS      40
`define TMF_TICK_NS     1000
`define TMF_TICK_CYC    ((`TMF_TICK_NS + `TMF_CLK_NS - 1) / `TMF_CLK_NS)
`define TMF_BYTE_US     16'h0001
// frame layout (bytes)
`define TMF_MTU         5'h10
`define TMF_HDR_LEN     2'h2
`define TMF_FRAME_LEN   16'h0013
`define TMF_CRC_INIT    8'h00
`define TMF_CRC_POLY    8'h07
// windows
`define TMF_NWIN        2
`define TMF_TMO_FOREVER 8'hff
`define TMF_TMO_NONE    8'h00
// epoch lengths in microseconds, chosen by select code
`define TMF_EPOCH_0     16'd1000
`define TMF_EPOCH_1     16'd2000
`define TMF_EPOCH_2     16'd5000
`define TMF_EPOCH_3     16'd10000
// register byte offsets
`define TMF_REG_CTRL    8'h00
`define TMF_REG_ADDR    8'h04
`define TMF_REG_HBEAT   8'h08
`define TMF_REG_STATUS  8'h0c
`define TMF_REG_MASK    8'h10
`define TMF_REG_TIME    8'h14
`define TMF_REG_WIN0    8'h20
`define TMF_WIN_STRIDE  8'h10
// control fields
`define TMF_CTRL_RUN    0
`define TMF_CTRL_ESEL_L 1
`define TMF_CTRL_ESEL_H 2
`define TMF_CTRL_SRST   3
// status bits
`define TMF_ST_TXDONE   0
`define TMF_ST_RXGOOD   1
`define TMF_ST_RXBAD    2
`define TMF_ST_EXPIRE   3
`define TMF_ST_W        4
`endif

// ==== verif/testbench.sv ====
// self-checking bench of the scheduled window framer
// assumes tmf_framer, tmf_enc_model and the bound checker
`include "tmf_consts.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DST = 8'h5a;
    localparam logic [7:0] SRC = 8'h3c;
    logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, er, slow = 0;
    logic ts_load = 0, sdu_valid = 0, sdu_last = 0, dec_valid = 0, dec_last = 0, stall = 0;
    logic [7:0]  paddr = 0, sdu_data = 0, dec_data = 0, enc_data_r, rxo_data_r;
    logic [15:0] ts_value = 0, tune_freq_r;
    logic [31:0] pwdata = 0, prdata, rd, seed = 35246;
    logic pready, pslverr, sdu_ready_r, enc_valid_r, enc_last_r, enc_ready, tx_on_r;
    logic dec_ready_r, rxo_valid_r, rxo_last_r, irq_r;
    logic [8:0]  sq[$], rq[$], eq[$];
    logic [31:0] wv[2][4] = '{'{32'h1234, 32'h0, 32'h3e8, 32'hff},
                              '{32'h4321, 32'h0, 32'h3e8, 32'h1}};
    int n_fail = 0, n_checks = 0;
    tmf_framer dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ts_load, .ts_value, .sdu_data, .sdu_valid, .sdu_last,
        .sdu_ready_r, .enc_data_r, .enc_valid_r, .enc_last_r, .enc_ready, .tx_on_r,
        .tune_freq_r, .dec_data, .dec_valid, .dec_last, .dec_ready_r, .rxo_data_r,
        .rxo_valid_r, .rxo_last_r, .irq_r);
    tmf_enc_model pm (.sys_clk, .resetn, .enc_data_r, .enc_valid_r, .enc_last_r,
        .enc_ready, .stall);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] b);
        c ^= b;
        for (int i = 0; i < 8; i++)
            c = c[7] ? {c[6:0], 1'b0} ^ `TMF_CRC_POLY : {c[6:0], 1'b0};
        return c;
    endfunction
    task automatic stop_test();
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo();
        n_fail++;
        stop_test();
    endtask
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) tmo();
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
        apb(0, a, 0);
        chk(nm, rd, exp);
    endtask
    task automatic tsync(logic [15:0] v);
        @(posedge sys_clk);
        ts_load <= 1;
        ts_value <= v;
        @(posedge sys_clk);
        ts_load <= 0;
    endtask
    // reference framing: 16-byte payload chunks, check byte last
    task automatic send_pkt(int len);
        logic [7:0] b, c;
        int k;
        k = 0;
        for (int i = 0; i < len; i++) begin
            b = 8'(rnd());
            if (k == 0) begin
                eq.push_back({1'b0, DST});
                eq.push_back({1'b0, SRC});
                c = crc8(crc8(8'h00, DST), SRC);
            end
            eq.push_back({1'b0, b});
            c = crc8(c, b);
            k++;
            if (k == 16 || i == len - 1) begin
                eq.push_back({1'b1, c});
                k = 0;
            end
            sq.push_back({i == len - 1, b});
        end
    endtask
    task automatic send_rx(int len, logic bad);
        logic [7:0] f[$];
        logic [7:0] c;
        int i;
        f = {DST, SRC};
        c = crc8(crc8(8'h00, DST), SRC);
        for (i = 0; i < len; i++) begin
            f.push_back(8'(rnd()));
            c = crc8(c, f[$]);
            if (!bad) eq.push_back({i == len - 1, f[$]});
        end
        f.push_back(c ^ {7'h0, bad});
        @(posedge sys_clk);
        foreach (f[j]) begin
            dec_valid <= 1;
            dec_data <= f[j];
            dec_last <= j == f.size() - 1;
            i = 0;
            do begin
                @(posedge sys_clk);
                i++;
            end while (dec_ready_r !== 1'b1 && i < 50);
            if (i == 50) tmo();
        end
        dec_valid <= 0;
        dec_last <= 0;
        dec_data <= ~f[$];
    endtask
    task automatic cmp(logic rx);
        int i;
        for (i = 0; i < 3000 && (rx ? rq.size() : pm.q.size()) < eq.size(); i++)
            @(posedge sys_clk);
        if (i == 3000) tmo();
        chk("byte count", rx ? rq.size() : pm.q.size(), eq.size());
        foreach (eq[j])
            chk("frame byte", {23'h0, rx ? rq[j] : pm.q[j]}, {23'h0, eq[j]});
        eq.delete();
        rq.delete();
        pm.q.delete();
    endtask
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (sdu_valid && sdu_ready_r)
            void'(sq.pop_front());
        sdu_valid <= sq.size() > 0;
        {sdu_last, sdu_data} <= sq.size() > 0 ? sq[0] : {1'b0, ~sdu_data};
        stall <= slow && rnd() % 3 == 0;
        if (rxo_valid_r)
            rq.push_back({rxo_last_r, rxo_data_r});
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        tmo();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1;
        rdc("ctrl", `TMF_REG_CTRL, 0);
        rdc("status", `TMF_REG_STATUS, 0);
        apb(0, 8'h1c, 0);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 0);
        wr(`TMF_REG_ADDR, {16'h0, DST, SRC});
        for (int n = 0; n < 2; n++)
            for (int r = 0; r < 4; r++)
                wr(8'(`TMF_REG_WIN0 + `TMF_WIN_STRIDE * n + 4 * r), wv[n][r]);
        for (int n = 0; n < 2; n++)
            for (int r = 0; r < 4; r++)
                rdc("window", 8'(`TMF_REG_WIN0 + `TMF_WIN_STRIDE * n + 4 * r), wv[n][r]);
        wr(`TMF_REG_CTRL, 1);
        wr(`TMF_REG_CTRL, 7);
        rdc("ctrl", `TMF_REG_CTRL, 1);
        slow <= 1;
        tsync(10);
        send_pkt(20);
        cmp(0);
        chk("tune freq", {16'h0, tune_freq_r}, wv[0][0]);
        rdc("status", `TMF_REG_STATUS, 1);
        wr(`TMF_REG_STATUS, 1);
        // too little time left: bytes must wait for the next epoch
        slow <= 0;
        tsync(990);
        send_pkt(3);
        repeat (150) @(posedge sys_clk);
        chk("early bytes", pm.q.size(), 0);
        chk("early tx", tx_on_r, 0);
        cmp(0);
        rdc("status", `TMF_REG_STATUS, 32'h9);
        wr(`TMF_REG_MASK, 32'h8);
        repeat (3) @(posedge sys_clk);
        chk("irq set", irq_r, 1);
        wr(`TMF_REG_STATUS, 32'hf);
        repeat (3) @(posedge sys_clk);
        chk("irq clear", irq_r, 0);
        send_rx(5, 0);
        repeat (40) @(posedge sys_clk);
        cmp(1);
        send_rx(16, 1);
        repeat (40) @(posedge sys_clk);
        cmp(1);
        rdc("status", `TMF_REG_STATUS, 32'h6);
        // soft reset keeps heartbeat, frequency and forever windows, drops address, status, mask and other timeouts
        wr(`TMF_REG_HBEAT, 32'h1234);
        wr(8'(`TMF_REG_WIN0 + `TMF_WIN_STRIDE + 12), 5);
        wr(`TMF_REG_CTRL, 32'h8);
        rdc("heartbeat", `TMF_REG_HBEAT, 32'h1234);
        rdc("addr", `TMF_REG_ADDR, 0);
        apb(0, `TMF_REG_TIME, 0);
        chk("time freq", {16'h0, rd[31:16]}, wv[0][0]);
        rdc("win0 tmo", 8'(`TMF_REG_WIN0 + 12), 32'hff);
        rdc("win1 tmo", 8'(`TMF_REG_WIN0 + `TMF_WIN_STRIDE + 12), 0);
        wr(`TMF_REG_ADDR, {16'h0, DST, SRC});
        wr(`TMF_REG_CTRL, 1);
        tsync(10);
        send_pkt(1);
        cmp(0);
        stop_test();
    end
endmodule // testbench
`default_nettype wire

// ==== verif/tmf_enc_model.sv ====
// codeblock coder stand-in: records framed bytes, stalls on request
// assumes the bench paces it through stall
`default_nettype none
module tmf_enc_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // framed bytes
    input  wire logic [7:0] enc_data_r,
    input  wire logic       enc_valid_r,
    input  wire logic       enc_last_r,
    output var  logic       enc_ready,
    // pacing
    input  wire logic       stall
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] q[$];
    initial enc_ready = 1'b0;
    always @(posedge sys_clk) begin
        // one codeblock per frame: the last flag closes it
        if (resetn && enc_valid_r && enc_ready)
            q.push_back({enc_last_r, enc_data_r});
        enc_ready <= resetn && !stall;
    end
endmodule // tmf_enc_model
`default_nettype wire

// ==== verif/tmf_framer_asserts.sv ====
// port-level assertions for the scheduled window framer
// assumes binding to tmf_framer, one clock, synchronous low reset
`default_nettype none
module tmf_framer_chk (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       resetn,
    // apb
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // transmit side
    input wire logic       sdu_ready_r,
    input wire logic [7:0] enc_data_r,
    input wire logic       enc_valid_r,
    input wire logic       enc_last_r,
    input wire logic       enc_ready,
    input wire logic       tx_on_r,
    // receive side
    input wire logic       dec_valid,
    input wire logic       dec_last,
    input wire logic       dec_ready_r,
    input wire logic       rxo_valid_r,
    input wire logic       rxo_last_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // bytes already taken in the current frame
    logic [4:0] nbyte_r;
    always @(posedge sys_clk) begin
        if (!resetn || (enc_valid_r && enc_ready && enc_last_r))
            nbyte_r <= 5'h00;
        else if (enc_valid_r && enc_ready)
            nbyte_r <= nbyte_r + 5'h01;
    end
    chk_pready_once: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    chk_pready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    chk_slverr_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    chk_enc_hold: assert property (enc_valid_r && !enc_ready |=>
        enc_valid_r && $stable(enc_data_r) && $stable(enc_last_r))
        else $error("coder byte dropped before taken");
    chk_tx_window: assert property (enc_valid_r |-> tx_on_r)
        else $error("byte offered outside a frame");
    chk_frame_len: assert property (enc_valid_r && enc_ready && enc_last_r |->
        nbyte_r >= 5'h03 && nbyte_r <= 5'h12)
        else $error("frame length out of bounds");
    chk_sdu_pulse: assert property (sdu_ready_r |=> !sdu_ready_r)
        else $error("input ready longer than one cycle");
    chk_rx_gap: assert property (dec_valid && dec_ready_r && dec_last |=> !dec_ready_r)
        else $error("decoder taken right after frame end");
    chk_rxo_last: assert property (rxo_last_r |-> rxo_valid_r)
        else $error("last marker without valid");
endmodule // tmf_framer_chk
bind tmf_framer tmf_framer_chk u_chk (.sys_clk, .resetn, .psel, .penable, .pready,
    .pslverr, .sdu_ready_r, .enc_data_r, .enc_valid_r, .enc_last_r, .enc_ready, .tx_on_r,
    .dec_valid, .dec_last, .dec_ready_r, .rxo_valid_r, .rxo_last_r);
`default_nettype wire

// ==== verilog/tmf_framer.v ====
// scheduled window framer: tx framing inside windows, rx check and de-framing
// assumes apb master on sys_clk, external codeblock coder on byte ports
`include "tmf_consts.vh"
`default_nettype none
module tmf_framer (
    // clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // time sync from link management
    input  wire        ts_load,
    input  wire [15:0] ts_value,
    // service data unit input
    input  wire [7:0]  sdu_data,
    input  wire        sdu_valid,
    input  wire        sdu_last,
    output reg         sdu_ready_r,
    // to codeblock encoder
    output reg  [7:0]  enc_data_r,
    output reg         enc_valid_r,
    output reg         enc_last_r,
    input  wire        enc_ready,
    output reg         tx_on_r,
    output reg  [15:0] tune_freq_r,
    // from codeblock decoder
    input  wire [7:0]  dec_data,
    input  wire        dec_valid,
    input  wire        dec_last,
    output reg         dec_ready_r,
    // delivered payload
    output reg  [7:0]  rxo_data_r,
    output reg         rxo_valid_r,
    output reg         rxo_last_r,
    // interrupt
    output reg         irq_r
);
    localparam integer TICK_CYC_I = `TMF_TICK_CYC;
    localparam [4:0] TICK_CYC = TICK_CYC_I[4:0];
    localparam [1:0] T_IDLE = 2'h0, T_HDR = 2'h1, T_PAY = 2'h2, T_CRC = 2'h3;
    localparam [1:0] R_HDR = 2'h0, R_PAY = 2'h1, R_PLAY = 2'h2;

    function [7:0] crc8;
        input [7:0] c;
        input [7:0] d;
        integer i;
        reg [7:0] x;
        begin
            x = c ^ d;
            for (i = 0; i < 8; i = i + 1) begin
                x = x[7] ? ((x << 1) ^ `TMF_CRC_POLY) : (x << 1);
            end
            crc8 = x;
        end
    endfunction

    function [15:0] epoch_len;
        input [1:0] s;
        begin
            case (s)
                2'h0: epoch_len = `TMF_EPOCH_0;
                2'h1: epoch_len = `TMF_EPOCH_1;
                2'h2: epoch_len = `TMF_EPOCH_2;
                default: epoch_len = `TMF_EPOCH_3;
            endcase
        end
    endfunction

    // control and retained state
    reg        run_r;
    reg [1:0]  esel_r;
    reg [7:0]  src_r;
    reg [7:0]  dst_r;
    reg [15:0] hbeat_r;
    reg [3:0]  stat_r;
    reg [3:0]  mask_r;
    reg [15:0] w_freq [0:`TMF_NWIN-1];
    reg [15:0] w_start [0:`TMF_NWIN-1];
    reg [15:0] w_stop [0:`TMF_NWIN-1];
    reg [7:0]  w_tmo [0:`TMF_NWIN-1];

    // time base
    reg [4:0]  div_r;
    reg        tick_r;
    reg [15:0] etime_r;
    wire       ewrap = tick_r & (etime_r >= epoch_len(esel_r) - 16'h0001);

    // apb decode
    wire       acc = psel & penable & pready;
    wire       wr = acc & pwrite;
    wire       srst = wr & (paddr == `TMF_REG_CTRL) & pwdata[`TMF_CTRL_SRST];
    wire [7:0] woff = paddr - `TMF_REG_WIN0;
    wire       win_hit = (paddr >= `TMF_REG_WIN0) &&
                         (woff < `TMF_WIN_STRIDE * `TMF_NWIN);
    wire       widx = woff[4];

    // active window search
    reg        act;
    reg [15:0] act_freq;
    reg [15:0] act_stop;
    integer    k;
    always @* begin
        act = 1'b0;
        act_freq = 16'h0000;
        act_stop = 16'h0000;
        for (k = `TMF_NWIN - 1; k >= 0; k = k - 1) begin
            if (w_tmo[k] != `TMF_TMO_NONE && etime_r >= w_start[k] &&
                etime_r < w_stop[k]) begin
                act = 1'b1;
                act_freq = w_freq[k];
                act_stop = w_stop[k];
            end
        end
    end
    wire [15:0] remain = act_stop - etime_r;
    wire        fits = act & (remain >= `TMF_FRAME_LEN * `TMF_BYTE_US);

    // events
    reg        ev_txdone;
    reg        ev_rxgood;
    reg        ev_rxbad;
    reg        ev_exp;

    // register file, windows and timing
    integer j;
    reg [3:0] ev_all;
    always @* begin
        ev_all = 4'h0;
        ev_all[`TMF_ST_TXDONE] = ev_txdone;
        ev_all[`TMF_ST_RXGOOD] = ev_rxgood;
        ev_all[`TMF_ST_RXBAD] = ev_rxbad;
        ev_all[`TMF_ST_EXPIRE] = ev_exp;
    end

    always @(posedge sys_clk) begin
        if (!resetn) begin
            run_r <= 1'b0;
            esel_r <= 2'h0;
            src_r <= 8'h00;
            dst_r <= 8'h00;
            hbeat_r <= 16'h0000;
            stat_r <= 4'h0;
            mask_r <= 4'h0;
            tune_freq_r <= 16'h0000;
            div_r <= 5'h00;
            tick_r <= 1'b0;
            etime_r <= 16'h0000;
            ev_exp <= 1'b0;
            irq_r <= 1'b0;
            for (j = 0; j < `TMF_NWIN; j = j + 1) begin
                w_freq[j] <= 16'h0000;
                w_start[j] <= 16'h0000;
                w_stop[j] <= 16'h0000;
                w_tmo[j] <= `TMF_TMO_NONE;
            end
        end else begin
            // microsecond tick from the system clock
            tick_r <= (div_r == TICK_CYC - 5'h01);
            div_r <= (div_r == TICK_CYC - 5'h01) ? 5'h00 : div_r + 5'h01;
            if (ts_load) begin
                etime_r <= ts_value;
                div_r <= 5'h00;
            end else if (ewrap) begin
                etime_r <= 16'h0000;
            end else if (tick_r) begin
                etime_r <= etime_r + 16'h0001;
            end
            // after stop, frequency holds: no clear path here
            if (act) begin
                tune_freq_r <= act_freq;
            end
            ev_exp <= 1'b0;
            for (j = 0; j < `TMF_NWIN; j = j + 1) begin
                if (ewrap && w_tmo[j] != `TMF_TMO_FOREVER &&
                    w_tmo[j] != `TMF_TMO_NONE) begin
                    w_tmo[j] <= w_tmo[j] - 8'h01;
                    if (w_tmo[j] == 8'h01) begin
                        ev_exp <= 1'b1;
                    end
                end
            end
            if (wr) begin
                case (paddr)
                    `TMF_REG_CTRL: begin
                        run_r <= pwdata[`TMF_CTRL_RUN];
                        if (!run_r) begin
                            esel_r <= pwdata[`TMF_CTRL_ESEL_H:`TMF_CTRL_ESEL_L];
                        end
                    end
                    `TMF_REG_ADDR: begin
                        src_r <= pwdata[7:0];
                        dst_r <= pwdata[15:8];
                    end
                    `TMF_REG_HBEAT: hbeat_r <= pwdata[15:0];
                    `TMF_REG_MASK: mask_r <= pwdata[`TMF_ST_W-1:0];
                    default: begin
                        if (win_hit) begin
                            case (woff[3:2])
                                2'h0: w_freq[widx] <= pwdata[15:0];
                                2'h1: w_start[widx] <= pwdata[15:0];
                                2'h2: w_stop[widx] <= pwdata[15:0];
                                default: w_tmo[widx] <= pwdata[7:0];
                            endcase
                        end
                    end
                endcase
            end
            // status: hardware set wins over write-one clear
            if (wr && paddr == `TMF_REG_STATUS) begin
                stat_r <= (stat_r & ~pwdata[`TMF_ST_W-1:0]) | ev_all;
            end else begin
                stat_r <= stat_r | ev_all;
            end
            irq_r <= |(stat_r & mask_r);
            if (srst) begin
                // soft reset keeps frequency, forever windows, heartbeat
                run_r <= 1'b0;
                src_r <= 8'h00;
                dst_r <= 8'h00;
                stat_r <= 4'h0;
                mask_r <= 4'h0;
                for (j = 0; j < `TMF_NWIN; j = j + 1) begin
                    if (w_tmo[j] != `TMF_TMO_FOREVER) begin
                        w_tmo[j] <= `TMF_TMO_NONE;
                    end
                end
            end
        end
    end

    // apb read and answer, one wait-free access cycle
    always @(posedge sys_clk) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    `TMF_REG_CTRL: prdata <= {28'h0, 1'b0, esel_r, run_r};
                    `TMF_REG_ADDR: prdata <= {16'h0, dst_r, src_r};
                    `TMF_REG_HBEAT: prdata <= {16'h0, hbeat_r};
                    `TMF_REG_STATUS: prdata <= {28'h0, stat_r};
                    `TMF_REG_MASK: prdata <= {28'h0, mask_r};
                    `TMF_REG_TIME: prdata <= {tune_freq_r, etime_r};
                    default: begin
                        if (win_hit) begin
                            case (woff[3:2])
                                2'h0: prdata <= {16'h0, w_freq[widx]};
                                2'h1: prdata <= {16'h0, w_start[widx]};
                                2'h2: prdata <= {16'h0, w_stop[widx]};
                                default: prdata <= {24'h0, w_tmo[widx]};
                            endcase
                        end else begin
                            pslverr <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // transmit framer
    reg [1:0] ts_r;
    reg [4:0] tcnt_r;
    reg [7:0] tcrc_r;
    reg       tlast_r;
    wire      slot = ~enc_valid_r | enc_ready;
    always @(posedge sys_clk) begin
        if (!resetn || srst) begin
            ts_r <= T_IDLE;
            tcnt_r <= 5'h00;
            tcrc_r <= `TMF_CRC_INIT;
            tlast_r <= 1'b0;
            sdu_ready_r <= 1'b0;
            enc_data_r <= 8'h00;
            enc_valid_r <= 1'b0;
            enc_last_r <= 1'b0;
            tx_on_r <= 1'b0;
            ev_txdone <= 1'b0;
        end else begin
            ev_txdone <= 1'b0;
            if (enc_valid_r && enc_ready) begin
                enc_valid_r <= 1'b0;
                enc_last_r <= 1'b0;
            end
            case (ts_r)
                T_IDLE: begin
                    // up until the coder takes the check byte
                    tx_on_r <= enc_valid_r & ~enc_ready;
                    if (run_r && sdu_valid && fits && slot) begin
                        ts_r <= T_HDR;
                        tx_on_r <= 1'b1;
                        enc_data_r <= dst_r;
                        enc_valid_r <= 1'b1;
                        tcrc_r <= crc8(`TMF_CRC_INIT, dst_r);
                        tcnt_r <= 5'h00;
                    end
                end
                T_HDR: begin
                    if (slot) begin
                        enc_data_r <= src_r;
                        enc_valid_r <= 1'b1;
                        tcrc_r <= crc8(tcrc_r, src_r);
                        ts_r <= T_PAY;
                    end
                end
                T_PAY: begin
                    if (sdu_ready_r && sdu_valid) begin
                        sdu_ready_r <= 1'b0;
                        enc_data_r <= sdu_data;
                        enc_valid_r <= 1'b1;
                        tcrc_r <= crc8(tcrc_r, sdu_data);
                        tcnt_r <= tcnt_r + 5'h01;
                        // packet end or mtu ends the frame
                        if (sdu_last || tcnt_r == `TMF_MTU - 5'h01) begin
                            ts_r <= T_CRC;
                        end
                    end else if (!enc_valid_r) begin
                        sdu_ready_r <= 1'b1;
                    end
                end
                default: begin
                    if (slot) begin
                        enc_data_r <= tcrc_r;
                        enc_valid_r <= 1'b1;
                        enc_last_r <= 1'b1;
                        ev_txdone <= 1'b1;
                        ts_r <= T_IDLE;
                    end
                end
            endcase
        end
    end

    // receive de-framer; frame held until its check is known
    reg [1:0] rs_r;
    reg [4:0] rcnt_r;
    reg [4:0] rplay_r;
    reg [1:0] rhdr_r;
    reg [7:0] rcrc_r;
    reg       rovf_r;
    reg [7:0] rbuf [0:`TMF_MTU-1];
    always @(posedge sys_clk) begin
        if (!resetn || srst) begin
            rs_r <= R_HDR;
            rcnt_r <= 5'h00;
            rplay_r <= 5'h00;
            rhdr_r <= 2'h0;
            rcrc_r <= `TMF_CRC_INIT;
            rovf_r <= 1'b0;
            dec_ready_r <= 1'b0;
            rxo_data_r <= 8'h00;
            rxo_valid_r <= 1'b0;
            rxo_last_r <= 1'b0;
            ev_rxgood <= 1'b0;
            ev_rxbad <= 1'b0;
        end else begin
            ev_rxgood <= 1'b0;
            ev_rxbad <= 1'b0;
            rxo_valid_r <= 1'b0;
            rxo_last_r <= 1'b0;
            dec_ready_r <= (rs_r != R_PLAY) && !(dec_valid && dec_ready_r && dec_last);
            case (rs_r)
                R_HDR: begin
                    if (dec_valid && dec_ready_r) begin
                        rcrc_r <= crc8(rcrc_r, dec_data);
                        rhdr_r <= rhdr_r + 2'h1;
                        if (dec_last) begin
                            ev_rxbad <= 1'b1;
                            rhdr_r <= 2'h0;
                            rcrc_r <= `TMF_CRC_INIT;
                        end else if (rhdr_r == `TMF_HDR_LEN - 2'h1) begin
                            rs_r <= R_PAY;
                        end
                    end
                end
                R_PAY: begin
                    if (dec_valid && dec_ready_r) begin
                        if (dec_last) begin
                            if (dec_data == rcrc_r && !rovf_r && rcnt_r != 5'h00) begin
                                rs_r <= R_PLAY;
                                rplay_r <= 5'h00;
                                ev_rxgood <= 1'b1;
                            end else begin
                                rs_r <= R_HDR;
                                ev_rxbad <= 1'b1;
                                rcnt_r <= 5'h00;
                            end
                            rhdr_r <= 2'h0;
                            rovf_r <= 1'b0;
                            rcrc_r <= `TMF_CRC_INIT;
                        end else begin
                            rcrc_r <= crc8(rcrc_r, dec_data);
                            if (rcnt_r == `TMF_MTU) begin
                                rovf_r <= 1'b1;
                            end else begin
                                rbuf[rcnt_r[3:0]] <= dec_data;
                                rcnt_r <= rcnt_r + 5'h01;
                            end
                        end
                    end
                end
                R_PLAY: begin
                    rxo_data_r <= rbuf[rplay_r[3:0]];
                    rxo_valid_r <= 1'b1;
                    rplay_r <= rplay_r + 5'h01;
                    if (rplay_r == rcnt_r - 5'h01) begin
                        rxo_last_r <= 1'b1;
                        rs_r <= R_HDR;
                        rcnt_r <= 5'h00;
                    end
                end
                default: rs_r <= R_HDR;
            endcase
        end
    end
endmodule // tmf_framer
`default_nettype wire
